// ### fsp_pkg.sv
// Purpose: shared constants of the streaming transform port block
// Assumes: one clock, asynchronous active-low reset
// Notes: counts are in clock cycles at 50 MHz
//
// Contract
// - Low reset clears all state asynchronously; buffer storage has no reset
// - Sample buses configurable 8 to 24 bits
// - Exponent output is log2(N)+1 bits wide
// - Direction 0 forward, 1 inverse
// - Direction strobe captures; applies at next start
// - Scale input: 2-bit stage fields, MSB first
// - Odd log2 size: last field one bit
// - Each stage shifts right by field
// - Scale strobe captures; applies at next start
// - Size input 3 bits if max 128
// - Size is log2 N, clamped 6..14
// - Size strobe captures; applies at next start, in the fast build only if five cycles ahead
// - Start begins N consecutive sample reads
// - Start during a read is ignored
// - Overflow flag belongs to block on output
// - Ready drops cycle after accepted start
// - Block end pulses on last sample
// - Output start pulses on first sample
// - Valid high whenever results are shown
// - Small build, reversed order: strobes ignored; the code drops them only while out_valid is high
// - Overflow flag raised during valid output
// - Exponent unsigned; true value is out*2^exp
package fsp_pkg;
  localparam int FSP_DW_MIN = 8;
  localparam int FSP_DW_MAX = 24;
  localparam int FSP_SF_MIN = 12;
  localparam int FSP_SF_MAX = 28;
  localparam int FSP_LOG_MIN = 6;
  localparam int FSP_LOG_MAX = 14;
  localparam int FSP_LOG_128 = 7;
  localparam int FSP_FIFO_DEPTH = 4;
  localparam int FSP_POINT_LEAD = 5;
  localparam logic FSP_DIR_FWD = 1'b0;
  localparam logic FSP_DIR_INV = 1'b1;
  localparam logic [3:0] FSP_PTS_LO = 4'h6;
  localparam logic [3:0] FSP_PTS_HI = 4'hE;
endpackage

// ### fsp_fifo.sv
// Purpose: small first-word-fall-through buffer between read and output stages
// Assumes: single clock, asynchronous active-low reset
// Notes: read data comes from a register, no memory primitive needed at this size
module fsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input logic mclk,
  input logic reset_n,
  // Fill side
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("fsp_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic push;
  logic pop;

  assign in_ready = (wp_q - rp_q) != (AW + 1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign out_data = mem_q[rp_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q <= '0;
    end else if (push) begin
      wp_q <= wp_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rp_q <= '0;
    end else if (pop) begin
      rp_q <= rp_q + 1'b1;
    end
  end

  // Storage needs no reset; pointers guard every read
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule

// ### fsp_core.sv
// Purpose: port behaviour of a streaming transform core
// Assumes: sources and consumer run on mclk; no synchronisers needed
// Notes: datapath is reduced to scaling, conjugation and overflow marking
module fsp_core
  import fsp_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int MAX_LOG2 = 7,
  parameter int SF_W = 14,
  parameter bit LOW_RES = 1'b1,
  parameter bit OUT_BITREV = 1'b1,
  // size port narrows for max 128
  parameter int PTS_W = (MAX_LOG2 == FSP_LOG_128) ? 3 : 4,
  parameter int EXP_W = MAX_LOG2 + 1
) (
  // Clock and reset
  input logic mclk,
  input logic reset_n,
  // Samples in
  input logic signed [DATA_W-1:0] dire,
  input logic signed [DATA_W-1:0] diim,
  // Results out
  output logic signed [DATA_W-1:0] dore,
  output logic signed [DATA_W-1:0] doim,
  output logic [EXP_W-1:0] exponent,
  input logic out_ready,
  // Configuration
  input logic dir_inv,
  input logic dir_set,
  input logic [SF_W-1:0] scale_fact,
  input logic scale_set,
  input logic [PTS_W-1:0] points_log2,
  input logic points_set,
  // Handshake
  input logic blk_start,
  output logic in_rdy,
  output logic blk_end,
  output logic out_start,
  output logic out_valid,
  output logic overflow
);
  import fsp_pkg::*;

  localparam int SMAX = (MAX_LOG2 + 1) / 2;
  localparam int CW = MAX_LOG2;
  localparam int WW = 2 * DATA_W + EXP_W + 2;

  // refuse widths the ports cannot take
  initial begin
    if (DATA_W < FSP_DW_MIN || DATA_W > FSP_DW_MAX) begin
      $error("fsp_core: DATA_W out of range");
    end
    if (SF_W < FSP_SF_MIN || SF_W > FSP_SF_MAX || SF_W < 2 * SMAX) begin
      $error("fsp_core: SF_W out of range");
    end
    if (MAX_LOG2 < FSP_LOG_128 || MAX_LOG2 > FSP_LOG_MAX) begin
      $error("fsp_core: MAX_LOG2 out of range");
    end
  end

  typedef enum logic [1:0] {
    FSP_IDLE = 2'b01,
    FSP_READ = 2'b10
  } fsp_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture

  fsp_state_e state_q;
  logic [CW-1:0] cnt_q;
  logic accept;
  logic cfg_open;
  logic dir_ok;
  logic sf_ok;
  logic pts_ok;
  logic dir_pend_q;
  logic [SF_W-1:0] sf_pend_q;
  logic [3:0] pts_pend_q;
  logic [2:0] pts_age_q;
  logic [3:0] pts_clamp;
  logic dir_act_q;
  logic [3:0] n_act_q;
  logic [EXP_W-1:0] shift_act_q;
  logic dir_nx;
  logic [SF_W-1:0] sf_nx;
  logic [3:0] n_nx;
  logic [EXP_W-1:0] shift_nx;

  // only an idle core takes a start
  assign accept = blk_start && state_q == FSP_IDLE;

  // in the small build with reversed output order, strobes are dropped while results stream out
  assign cfg_open = !(LOW_RES && OUT_BITREV && out_valid);
  assign dir_ok = dir_set && cfg_open;
  assign sf_ok = scale_set && cfg_open;
  assign pts_ok = points_set && cfg_open;

  // clamp size to the legal and built range
  always_comb begin
    pts_clamp = 4'(points_log2);
    if (pts_clamp < FSP_PTS_LO) begin
      pts_clamp = FSP_PTS_LO;
    end
    if (pts_clamp > FSP_PTS_HI) begin
      pts_clamp = FSP_PTS_HI;
    end
    if (pts_clamp > 4'(MAX_LOG2)) begin
      pts_clamp = 4'(MAX_LOG2);
    end
  end

  // direction pending until a block starts
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dir_pend_q <= FSP_DIR_FWD;
    end else if (dir_ok) begin
      dir_pend_q <= dir_inv;
    end
  end

  // scale factors pending until a block starts
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sf_pend_q <= '0;
    end else if (sf_ok) begin
      sf_pend_q <= scale_fact;
    end
  end

  // size pending until a block starts
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pts_pend_q <= 4'(MAX_LOG2);
    end else if (pts_ok) begin
      pts_pend_q <= pts_clamp;
    end
  end

  // age of the size strobe, for the fast build's lead time
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pts_age_q <= 3'(FSP_POINT_LEAD);
    end else if (pts_ok) begin
      pts_age_q <= '0;
    end else if (pts_age_q != 3'(FSP_POINT_LEAD)) begin
      pts_age_q <= pts_age_q + 1'b1;
    end
  end

  // a strobe in the start cycle counts for that block; in the fast build a size strobe does not
  // A size strobe five cycles ahead of the start has aged four by then
  always_comb begin
    dir_nx = dir_ok ? dir_inv : dir_pend_q;
    sf_nx = sf_ok ? scale_fact : sf_pend_q;
    if (LOW_RES) begin
      n_nx = pts_ok ? pts_clamp : pts_pend_q;
    end else begin
      n_nx = (pts_age_q >= 3'(FSP_POINT_LEAD - 1)) ? pts_pend_q : n_act_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage scale fields

  logic [3:0] nstg;
  logic [EXP_W-1:0] acc [SMAX+1];

  assign nstg = (n_nx + 4'h1) >> 1;
  assign acc[0] = '0;

  // stage fields taken from the top down
  for (genvar i = 0; i < SMAX; i++) begin : g_stage
    logic [1:0] fld;
    logic [1:0] sh;
    assign fld = sf_nx[SF_W-1-2*i -: 2];
    // last field of an odd size keeps one bit
    always_comb begin
      sh = 2'h0;
      if (4'(i) < nstg) begin
        sh = (n_nx[0] && 4'(i) == nstg - 4'h1) ? {1'b0, fld[0]} : fld;
      end
    end
    assign acc[i+1] = acc[i] + EXP_W'(sh);
  end

  assign shift_nx = acc[SMAX];

  // Block configuration frozen at the accepted start
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dir_act_q <= FSP_DIR_FWD;
      n_act_q <= 4'(MAX_LOG2);
      shift_act_q <= '0;
    end else if (accept) begin
      dir_act_q <= dir_nx;
      n_act_q <= n_nx;
      shift_act_q <= shift_nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input read sequence

  logic [CW:0] n_pow;
  logic [CW-1:0] cnt_last;
  logic [CW-1:0] cnt_pen;
  logic take;
  logic in_rdy_q;
  logic blk_end_q;
  logic fifo_in_rdy;
  logic fifo_empty;

  assign n_pow = (CW + 1)'(1) << n_act_q;
  assign cnt_last = CW'(n_pow - 1'b1);
  assign cnt_pen = CW'(n_pow - 2'h2);

  // the start cycle carries sample zero
  assign take = accept || state_q == FSP_READ;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= FSP_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        FSP_IDLE: begin
          if (accept) begin
            state_q <= FSP_READ;
            cnt_q <= CW'(1);
          end
        end
        FSP_READ: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == cnt_last) begin
            state_q <= FSP_IDLE;
            cnt_q <= '0;
          end
        end
        default: begin
          state_q <= FSP_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // registered so it lands on the last sample
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      blk_end_q <= 1'b0;
    end else begin
      blk_end_q <= state_q == FSP_READ && cnt_q == cnt_pen;
    end
  end

  // ready falls after a start; waits for an empty buffer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      in_rdy_q <= 1'b0;
    end else if (accept) begin
      in_rdy_q <= 1'b0;
    end else begin
      in_rdy_q <= fifo_empty && (state_q == FSP_IDLE || cnt_q == cnt_last);
    end
  end

  assign in_rdy = in_rdy_q;
  assign blk_end = blk_end_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sample processing into the buffer

  logic use_dir;
  logic [EXP_W-1:0] use_sh;
  logic signed [DATA_W-1:0] im_c;
  logic neg_ovf;
  logic lost_q;
  logic [WW-1:0] wr_word;
  logic [WW-1:0] rd_word;
  logic fifo_out_valid;
  logic fifo_pop;

  assign use_dir = accept ? dir_nx : dir_act_q;
  assign use_sh = accept ? shift_nx : shift_act_q;
  // Inverse runs as conjugate; the most negative value cannot be negated
  assign neg_ovf = use_dir == FSP_DIR_INV && diim == {1'b1, {(DATA_W-1){1'b0}}};
  assign im_c = (use_dir == FSP_DIR_INV) ? -diim : diim;

  // total right shift is the stage sum
  assign wr_word = {accept, neg_ovf || lost_q, use_sh, dire >>> use_sh, im_c >>> use_sh};

  // A sample that finds the buffer full is lost and flagged on the next one
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lost_q <= 1'b0;
    end else if (take) begin
      lost_q <= !fifo_in_rdy;
    end
  end

  fsp_fifo #(
    .WIDTH(WW),
    .DEPTH(FSP_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(take),
    .in_ready(fifo_in_rdy),
    .in_data(wr_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(rd_word)
  );

  assign fifo_empty = !fifo_out_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Output register stage

  logic signed [DATA_W-1:0] dore_q;
  logic signed [DATA_W-1:0] doim_q;
  logic [EXP_W-1:0] exp_q;
  logic out_start_q;
  logic out_valid_q;
  logic overflow_q;

  // Consumer back-pressure stalls the drain side
  assign fifo_pop = fifo_out_valid && (out_ready || !out_valid_q);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_q <= 1'b0;
    end else if (fifo_pop) begin
      out_valid_q <= 1'b1;
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dore_q <= '0;
      doim_q <= '0;
      exp_q <= '0;
    end else if (fifo_pop) begin
      dore_q <= rd_word[2*DATA_W-1:DATA_W];
      doim_q <= rd_word[DATA_W-1:0];
      exp_q <= rd_word[2*DATA_W+EXP_W-1:2*DATA_W];
    end
  end

  // start marks the first result of a block
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_start_q <= 1'b0;
    end else if (fifo_pop) begin
      out_start_q <= rd_word[WW-1];
    end else if (out_ready) begin
      out_start_q <= 1'b0;
    end
  end

  // sticky within the output block, cleared at its start
  // Limitation: results shown before the first fault are not flagged
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      overflow_q <= 1'b0;
    end else if (fifo_pop) begin
      overflow_q <= rd_word[WW-2] || (overflow_q && !rd_word[WW-1]);
    end else if (out_ready) begin
      overflow_q <= 1'b0;
    end
  end

  assign dore = dore_q;
  assign doim = doim_q;
  assign exponent = exp_q;
  assign out_start = out_start_q;
  assign out_valid = out_valid_q;
  assign overflow = overflow_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  ready_drop_a: assert property (accept |=> !in_rdy)
    else $error("ready not low after start");

  end_pulse_a: assert property (blk_end |=> !blk_end)
    else $error("block end longer than one cycle");

  end_align_a: assert property (blk_end |-> state_q == FSP_READ && cnt_q == cnt_last)
    else $error("block end not on last sample");

  read_run_a: assert property (accept |=> (state_q == FSP_READ)[*8])
    else $error("read broke early");

  start_ign_a: assert property (
    (state_q == FSP_READ && cnt_q != cnt_last) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("read disturbed by start");

  size_clamp_a: assert property (n_act_q >= FSP_PTS_LO && n_act_q <= FSP_PTS_HI)
    else $error("size outside clamp");

  dir_take_a: assert property (accept && dir_ok |=> dir_act_q == $past(dir_inv))
    else $error("direction not applied");

  ostart_valid_a: assert property (out_start |-> out_valid)
    else $error("output start without valid");

  ovf_valid_a: assert property (overflow |-> out_valid)
    else $error("overflow outside valid output");

  exp_stable_a: assert property (
    out_valid && out_ready ##1 out_valid && !out_start |-> $stable(exponent))
    else $error("exponent changed within block");

  ign_cfg_a: assert property (
    LOW_RES && OUT_BITREV && out_valid && dir_set |=> $stable(dir_pend_q))
    else $error("strobe taken during output");

  blk_cov: cover property (accept ##1 (state_q == FSP_READ)[*3] ##[1:1000] blk_end);
  out_cov: cover property (out_start ##1 out_valid[*4]);
  ovf_cov: cover property (out_valid && overflow);
  stall_cov: cover property (take && !fifo_in_rdy);
endmodule

// ### fsp_model.sv
// Purpose: sample source, configuration driver and result consumer facing fsp_core
// Assumes: every source, configuration and consumer signal it drives changes on the falling edge of mclk
// Notes: keeps a queue of expected results; holds its own error and check counts
module fsp_model
  import fsp_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int EXP_W = 8,
  parameter int SF_W = 14,
  parameter int PTS_W = 3
) (
  // Clock
  input logic mclk,
  // Source side
  output logic signed [DATA_W-1:0] dire,
  output logic signed [DATA_W-1:0] diim,
  output logic blk_start,
  input logic in_rdy,
  input logic blk_end,
  // Configuration side
  output logic dir_inv,
  output logic dir_set,
  output logic [SF_W-1:0] scale_fact,
  output logic scale_set,
  output logic [PTS_W-1:0] points_log2,
  output logic points_set,
  // Consumer side
  output logic out_ready,
  input logic signed [DATA_W-1:0] dore,
  input logic signed [DATA_W-1:0] doim,
  input logic [EXP_W-1:0] exponent,
  input logic out_start,
  input logic out_valid,
  input logic overflow,
  // Counts
  output int err_n,
  output int chk_n,
  output logic hung
);
  localparam int W = 48;
  logic [W-1:0] exp_q[$];
  int mid_at = -1;
  int drop_at = -1;
  int took_n = 0;

  initial begin
    dire = '0;
    diim = '0;
    blk_start = 1'b0;
    dir_inv = 1'b0;
    dir_set = 1'b0;
    scale_fact = '0;
    scale_set = 1'b0;
    points_log2 = '0;
    points_set = 1'b0;
    out_ready = 1'b1;
    err_n = 0;
    chk_n = 0;
    hung = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [W-1:0] got, input logic [W-1:0] want);
    chk_n++;
    if (got !== want) begin
      err_n++;
      $display("[ERR] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  task automatic step;
    @(negedge mclk);
    // Only a raised strobe is lowered, so a following cfg writes it once
    if (dir_set) dir_set = 1'b0;
    if (scale_set) scale_set = 1'b0;
    if (points_set) points_set = 1'b0;
  endtask

  task automatic cfg(input logic d, input logic [SF_W-1:0] s, input logic [PTS_W-1:0] p);
    dir_inv = d;
    scale_fact = s;
    points_log2 = p;
    dir_set = 1'b1;
    scale_set = 1'b1;
    points_set = 1'b1;
  endtask

  task automatic wait_rdy;
    int k;
    k = 0;
    while (in_rdy !== 1'b1 && k < 300) begin
      step();
      k++;
    end
    if (k == 300) hung = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic send_block(input int n, input logic inv, input int sh, input int ovf_at,
                            input int st, input int sl, input int dup);
    logic signed [DATA_W-1:0] r;
    logic signed [DATA_W-1:0] m;
    logic v;
    int k;
    v = 1'b0;
    wait_rdy();
    for (int i = 0; i < n; i++) begin
      r = DATA_W'(i * 37 - 1000);
      m = (i == ovf_at) ? {1'b1, {(DATA_W - 1){1'b0}}} : DATA_W'(500 - i * 53);
      // one sample a cycle, first with start
      dire = r;
      diim = m;
      blk_start = (i == 0 || i == dup);
      out_ready = !(i >= st && i < st + sl);
      if (i == mid_at) begin
        dir_inv = ~dir_inv;
        dir_set = 1'b1;
      end
      v = v | (i == ovf_at) | (drop_at >= 0 && i == drop_at + 1);
      if (inv) m = -m;
      // A sample refused by the full buffer never comes out
      if (i != drop_at) exp_q.push_back(W'({r >>> sh, m >>> sh, EXP_W'(sh), i == 0, v}));
      chk(W'(blk_end), W'(i == n - 1));
      if (i == 1) chk(W'(in_rdy), W'(0));
      step();
    end
    // Released bus shows a changed value, never the last sample
    blk_start = 1'b0;
    out_ready = 1'b1;
    dire = ~r;
    diim = ~diim;
    chk(W'(blk_end), W'(0));
    k = 0;
    while (exp_q.size() > 0 && k < 300) begin
      step();
      k++;
    end
    if (k == 300) hung = 1'b1;
    mid_at = -1;
    drop_at = -1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // Design outputs read before the edge's own updates land
  always @(posedge mclk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      took_n++;
      if (exp_q.size() == 0) chk(W'(1), W'(0));
      else chk(W'({dore, doim, exponent, out_start, overflow}), exp_q.pop_front());
    end
  end
endmodule

// ### fsp_core_tb.sv
// Purpose: self-checking bench for fsp_core and its output buffer
// Assumes: 50 MHz mclk, inputs change on the falling edge
// Notes: ordinary cases run from a table; awkward ones follow by hand
module fsp_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fsp_pkg::*;

  typedef struct {logic d; logic [13:0] sf; logic [2:0] p; int n; int sh;} fsp_row_s;
  fsp_row_s rows[5] = '{
    '{1'b0, 14'h0000, 3'h6, 64, 0},
    '{1'b1, 14'h3900, 3'h6, 64, 6},
    '{1'b0, 14'h00C0, 3'h7, 128, 1},
    '{1'b1, 14'h2A80, 3'h7, 128, 6},
    '{1'b0, 14'h1400, 3'h2, 64, 2}
  };
  logic mclk = 1'b0;
  logic reset_n;
  logic signed [15:0] dire, diim, dore, doim;
  logic [7:0] exponent;
  logic out_ready, dir_inv, dir_set, scale_set, points_set, blk_start;
  logic in_rdy, blk_end, out_start, out_valid, overflow, hung;
  logic [13:0] scale_fact;
  logic [2:0] points_log2;
  int err_n, chk_n, err_count, tests_run, k;

  always #10 mclk = ~mclk;

  fsp_core uut (.mclk, .reset_n, .dire, .diim, .dore, .doim, .exponent, .out_ready,
                .dir_inv, .dir_set, .scale_fact, .scale_set, .points_log2, .points_set,
                .blk_start, .in_rdy, .blk_end, .out_start, .out_valid, .overflow);
  fsp_model um (.mclk, .dire, .diim, .blk_start, .in_rdy, .blk_end, .dir_inv, .dir_set,
                .scale_fact, .scale_set, .points_log2, .points_set, .out_ready, .dore,
                .doim, .exponent, .out_start, .out_valid, .overflow, .err_n, .chk_n, .hung);

  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    err_count = err_n;
    tests_run = chk_n;
    $display("Mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge hung) begin
    um.chk(48'(1), 48'(0));
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    // Stalls of two cycles stay inside the buffer's reach
    foreach (rows[j]) begin
      um.cfg(rows[j].d, rows[j].sf, rows[j].p);
      um.step();
      um.send_block(rows[j].n, rows[j].d, rows[j].sh, -1, 20, 2, -1);
    end
    // Strobes in the start cycle itself, and a second start mid-read
    um.wait_rdy();
    um.cfg(1'b1, 14'h1000, 3'h7);
    um.send_block(128, 1'b1, 1, -1, 5, 2, 30);
    // Strobe while results flow is dropped; next block keeps inverse
    um.mid_at = 20;
    um.send_block(128, 1'b1, 1, -1, 999, 0, -1);
    um.send_block(128, 1'b1, 1, 40, 999, 0, -1);
    // Reset takes hold before any clock edge
    @(negedge mclk);
    reset_n = 1'b0;
    #2;
    um.chk(48'({in_rdy, blk_end, out_start, out_valid, overflow}), 48'(0));
    um.chk(48'({dore, doim, exponent}), 48'(0));
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    um.cfg(1'b0, 14'h0000, 3'h6);
    um.step();
    k = um.took_n;
    um.send_block(64, 1'b0, 0, -1, 999, 0, -1);
    um.chk(48'(um.took_n - k), 48'(64));
    // One stall cycle past the buffer's reach loses a sample; the next one is flagged
    um.drop_at = 20 + FSP_FIFO_DEPTH - 1;
    k = um.took_n;
    um.send_block(64, 1'b0, 0, -1, 20, FSP_FIFO_DEPTH - 1, -1);
    um.chk(48'(um.took_n - k), 48'(64 - 1));
    um.chk(48'({out_valid, in_rdy, overflow}), 48'(3'b010));
    end_sim();
  end
endmodule
